// ===== tcp_card.sv
// Functional notes
// - Terminal sends command only when card advertises
// - Data length is Lc; no response data
// - Data is one container: A9, length, objects
// - Skip private objects with top two tag bits
// - Recognise tags 80, 81, 82, 83
// - Terminal always sends power object each session
// - Power object: voltage class, current, frequency
// - Voltage class keeps only defined bits
// - Current valid only from 0A to 3C
// - Frequency in 0.1 MHz steps; FF none
// - Terminal should report 10, 30, 60 mA; tcp_term sends max_current as given, unchecked
// - Terminal sends extended channel object when supported
// - Extended channel object of any length sets flag
// - Channel limit 3, or 19 when extended
// - Terminal sends interface object when supported
// - Interface object: first value byte only used
// - Bit b1 flags contactless front-end link
// - Terminal sends embedded card object when supported
// - Embedded card bytes captured opaque
//
`timescale 1ns/1ps
`include "tcp_defs.svh"
module tcp_card #(
   parameter int EMB_DEPTH = 16,
   parameter logic [7:0] VCLASS_MASK = 8'hff,
   parameter bit ADVERTISE = 1'b1
) (
   input wire logic clock,
   input wire logic arst_n,
   tcp_link_if.card lnk,
   input wire logic [$clog2(EMB_DEPTH)-1:0] emb_rd_addr,
   output logic [7:0] emb_rd_data,
   output logic [7:0] emb_len,
   output logic embedded_provisioned_card,
   output logic pwr_seen,
   output logic [7:0] volt_class,
   output logic [7:0] max_current,
   output logic current_ok,
   output logic [7:0] clk_freq,
   output logic freq_ok,
   output logic ext_channels,
   output logic [4:0] max_channel,
   output logic contactless_frontend_link
);
   import tcp_pkg::*;

   localparam int AW = $clog2(EMB_DEPTH);
   localparam logic [8:0] DEPTH9 = 9'(EMB_DEPTH);

   if (EMB_DEPTH < 2 || EMB_DEPTH > 256 || (1 << AW) != EMB_DEPTH) begin : g_bad_depth
      $error("tcp_card: EMB_DEPTH must be a power of two from 2 to 256");
   end

   typedef struct packed {
      tcp_card_st_t st;
      logic [7:0] lc_left;
      logic [7:0] outer_left;
      logic [7:0] obj_left;
      logic [7:0] obj_idx;
      logic [7:0] tag;
      logic err;
      logic adv;
      logic resp_valid;
      logic resp_ok;
      logic pwr_seen;
      logic [7:0] volt;
      logic [7:0] cur;
      logic cur_ok;
      logic [7:0] freq;
      logic freq_ok;
      logic ext;
      logic [4:0] max_ch;
      logic clf;
      logic emb_seen;
      logic [7:0] emb_len;
      logic [EMB_DEPTH-1:0][7:0] emb;
      logic [7:0] emb_rd;
   } tcp_card_state_t;

   tcp_card_state_t q, d;

   // ==================================================
   // Container walker
   always_comb begin
      logic [7:0] b;
      logic [7:0] outer_nx;
      b = lnk.byte_data;
      outer_nx = q.outer_left - 8'h01;
      d = q;
      d.adv = ADVERTISE;
      d.resp_valid = 1'b0;
      d.emb_rd = q.emb[emb_rd_addr];
      d.max_ch = q.ext ? `TCP_CH_EXT : `TCP_CH_STD;
      if (lnk.session_new) begin
         // Defaults mean "not indicated"; a session also aborts a command in flight
         d = '0;
         d.adv = ADVERTISE;
         d.freq = `TCP_FREQ_NONE;
         d.max_ch = `TCP_CH_STD;
      end else if (lnk.cmd_valid) begin
         d.lc_left = lnk.cmd_lc;
         d.err = 1'b0;
         d.st = TCP_C_OUT_TAG;
         if (lnk.cmd_lc == 8'h00) begin
            d.resp_valid = 1'b1;
            d.resp_ok = 1'b0;
            d.st = TCP_C_IDLE;
         end
      end else if (lnk.byte_valid && q.st != TCP_C_IDLE) begin
         d.lc_left = q.lc_left - 8'h01;
         unique case (q.st)
            TCP_C_IDLE: begin
            end
            TCP_C_OUT_TAG: begin
               if (b != `TCP_TAG_CONT) begin
                  d.err = 1'b1;
               end
               d.st = TCP_C_OUT_LEN;
            end
            TCP_C_OUT_LEN: begin
               d.outer_left = b;
               d.st = (b == 8'h00) ? TCP_C_TAIL : TCP_C_IN_TAG;
            end
            TCP_C_IN_TAG: begin
               d.tag = b;
               d.outer_left = outer_nx;
               d.st = TCP_C_IN_LEN;
            end
            TCP_C_IN_LEN: begin
               if (q.outer_left == 8'h00) begin
                  d.err = 1'b1;
                  d.st = TCP_C_TAIL;
               end else begin
                  d.obj_left = b;
                  d.obj_idx = 8'h00;
                  d.outer_left = outer_nx;
                  if (q.tag == `TCP_TAG_EXT) begin
                     // Any length counts as zero; its value bytes are skipped
                     d.ext = 1'b1;
                  end
                  if (q.tag == `TCP_TAG_EMB) begin
                     d.emb_seen = 1'b1;
                     d.emb_len = b;
                  end
                  if (b == 8'h00) begin
                     d.st = (outer_nx == 8'h00) ? TCP_C_TAIL : TCP_C_IN_TAG;
                  end else begin
                     d.st = TCP_C_IN_VAL;
                  end
               end
            end
            TCP_C_IN_VAL: begin
               if (q.outer_left == 8'h00) begin
                  // Object claims more bytes than the container holds
                  d.err = 1'b1;
                  d.st = TCP_C_TAIL;
               end else begin
                  if (q.tag == `TCP_TAG_PWR) begin
                     if (q.obj_idx == `TCP_PWR_IDX_VOLT) begin
                        d.volt = b & VCLASS_MASK;
                     end
                     if (q.obj_idx == `TCP_PWR_IDX_CUR) begin
                        d.cur = b;
                        d.cur_ok = (b >= `TCP_CUR_MIN) && (b <= `TCP_CUR_MAX);
                     end
                     if (q.obj_idx == `TCP_PWR_IDX_FREQ) begin
                        d.freq = b;
                        d.freq_ok = (b >= `TCP_FREQ_MIN) && (b != `TCP_FREQ_NONE);
                        d.pwr_seen = 1'b1;
                     end
                  end else if (q.tag == `TCP_TAG_IFC) begin
                     if (q.obj_idx == 8'h00) begin
                        d.clf = b[`TCP_CLF_BIT];
                     end
                  end else if (q.tag == `TCP_TAG_EMB) begin
                     // Bytes past the store depth are dropped; emb_len still tells the true size
                     if ({1'b0, q.obj_idx} < DEPTH9) begin
                        d.emb[q.obj_idx[AW-1:0]] = b;
                     end
                  end
                  // Private and unknown tags fall through and are skipped
                  d.obj_idx = q.obj_idx + 8'h01;
                  d.obj_left = q.obj_left - 8'h01;
                  d.outer_left = outer_nx;
                  if (q.obj_left == 8'h01) begin
                     d.st = (outer_nx == 8'h00) ? TCP_C_TAIL : TCP_C_IN_TAG;
                  end
               end
            end
            TCP_C_TAIL: begin
               // Bytes after the container end
               d.err = 1'b1;
            end
            default: begin
               d.st = TCP_C_IDLE;
            end
         endcase
         if (q.lc_left == 8'h01) begin
            d.resp_valid = 1'b1;
            d.resp_ok = !d.err && (d.st == TCP_C_TAIL);
            d.st = TCP_C_IDLE;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign lnk.cap_adv = q.adv;
   assign lnk.resp_valid = q.resp_valid;
   assign lnk.resp_ok = q.resp_ok;
   assign emb_rd_data = q.emb_rd;
   assign emb_len = q.emb_len;
   assign embedded_provisioned_card = q.emb_seen;
   assign pwr_seen = q.pwr_seen;
   assign volt_class = q.volt;
   assign max_current = q.cur;
   assign current_ok = q.cur_ok;
   assign clk_freq = q.freq;
   assign freq_ok = q.freq_ok;
   assign ext_channels = q.ext;
   assign max_channel = q.max_ch;
   assign contactless_frontend_link = q.clf;
endmodule

// ===== tcp_defs.svh
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH

// ==================================================
// Tags and lengths of the capability container
`define TCP_TAG_CONT 8'ha9
`define TCP_TAG_PWR 8'h80
`define TCP_TAG_EXT 8'h81
`define TCP_TAG_IFC 8'h82
`define TCP_TAG_EMB 8'h83
`define TCP_PWR_LEN 8'h03
`define TCP_EXT_LEN 8'h00
`define TCP_IFC_LEN 8'h01
`define TCP_PRIV_MASK 8'hc0

// ==================================================
// Value ranges, field positions and reset values
`define TCP_CUR_MIN 8'h0a
`define TCP_CUR_MAX 8'h3c
`define TCP_FREQ_MIN 8'h0a
`define TCP_FREQ_NONE 8'hff
`define TCP_PWR_IDX_VOLT 8'h00
`define TCP_PWR_IDX_CUR 8'h01
`define TCP_PWR_IDX_FREQ 8'h02
`define TCP_CLF_BIT 0
`define TCP_CH_STD 5'h03
`define TCP_CH_EXT 5'h13
`define TCP_HDR_LEN 8'h02

`endif

// ===== tcp_pkg.sv
package tcp_pkg;

   typedef enum logic [2:0] {
      TCP_C_IDLE = 3'b000,
      TCP_C_OUT_TAG = 3'b001,
      TCP_C_OUT_LEN = 3'b010,
      TCP_C_IN_TAG = 3'b011,
      TCP_C_IN_LEN = 3'b100,
      TCP_C_IN_VAL = 3'b101,
      TCP_C_TAIL = 3'b110
   } tcp_card_st_t;

   typedef enum logic [1:0] {
      TCP_T_IDLE = 2'b00,
      TCP_T_SEND = 2'b01,
      TCP_T_WAIT = 2'b10
   } tcp_term_st_t;

endpackage

// ===== tcp_link_if.sv
`timescale 1ns/1ps
interface tcp_link_if;
   logic session_new;
   logic cmd_valid;
   logic [7:0] cmd_lc;
   logic byte_valid;
   logic [7:0] byte_data;
   logic cap_adv;
   logic resp_valid;
   logic resp_ok;

   modport card (
      input session_new,
      input cmd_valid,
      input cmd_lc,
      input byte_valid,
      input byte_data,
      output cap_adv,
      output resp_valid,
      output resp_ok
   );

   modport term (
      output session_new,
      output cmd_valid,
      output cmd_lc,
      output byte_valid,
      output byte_data,
      input cap_adv,
      input resp_valid,
      input resp_ok
   );
endinterface

// ===== tcp_term.sv
`timescale 1ns/1ps
`include "tcp_defs.svh"
module tcp_term #(
   parameter int EMB_MAX = 8
) (
   input wire logic clock,
   input wire logic arst_n,
   tcp_link_if.term lnk,
   input wire logic session_start,
   input wire logic start,
   input wire logic [7:0] volt_class,
   input wire logic [7:0] max_current,
   input wire logic [7:0] clk_freq,
   input wire logic ext_en,
   input wire logic clf_en,
   input wire logic [7:0] clf_byte,
   input wire logic emb_en,
   input wire logic [7:0] emb_len,
   input wire logic [EMB_MAX*8-1:0] emb_data,
   output logic busy,
   output logic done,
   output logic ok,
   output logic refused
);
   import tcp_pkg::*;

   localparam int MAXLEN = 14 + EMB_MAX;
   localparam logic [7:0] EMAX8 = 8'(EMB_MAX);

   // Message positions are byte counts, so the whole command must fit in eight bits
   if (EMB_MAX < 1 || MAXLEN > 255) begin : g_bad_max
      $error("tcp_term: EMB_MAX out of range");
   end

   typedef struct packed {
      tcp_term_st_t st;
      logic [MAXLEN-1:0][7:0] msg;
      logic [7:0] lc;
      logic [7:0] pos;
      logic session_new;
      logic cmd_valid;
      logic byte_valid;
      logic [7:0] byte_data;
      logic busy;
      logic done;
      logic ok;
      logic refused;
   } tcp_term_state_t;

   tcp_term_state_t q, d;

   // ==================================================
   // Command assembly and sequencing
   always_comb begin
      logic [MAXLEN-1:0][7:0] m;
      logic [7:0] k;
      logic [7:0] el;
      m = '0;
      k = 8'h07;
      el = (emb_len > EMAX8) ? EMAX8 : emb_len;
      m[0] = `TCP_TAG_CONT;
      m[2] = `TCP_TAG_PWR;
      m[3] = `TCP_PWR_LEN;
      m[4] = volt_class;
      m[5] = max_current;
      m[6] = clk_freq;
      if (ext_en) begin
         m[k] = `TCP_TAG_EXT;
         m[k+8'h01] = `TCP_EXT_LEN;
         k = k + 8'h02;
      end
      if (clf_en) begin
         m[k] = `TCP_TAG_IFC;
         m[k+8'h01] = `TCP_IFC_LEN;
         m[k+8'h02] = clf_byte;
         k = k + 8'h03;
      end
      if (emb_en) begin
         m[k] = `TCP_TAG_EMB;
         m[k+8'h01] = el;
         k = k + 8'h02;
         for (int i = 0; i < EMB_MAX; i++) begin
            if (8'(i) < el) begin
               m[k+8'(i)] = emb_data[i*8 +: 8];
            end
         end
         k = k + el;
      end
      m[1] = k - `TCP_HDR_LEN;

      d = q;
      d.session_new = session_start;
      d.cmd_valid = 1'b0;
      d.byte_valid = 1'b0;
      d.done = 1'b0;
      d.refused = 1'b0;
      unique case (q.st)
         TCP_T_IDLE: begin
            if (start) begin
               if (!lnk.cap_adv) begin
                  d.refused = 1'b1;
               end else begin
                  d.msg = m;
                  d.lc = k;
                  d.cmd_valid = 1'b1;
                  d.pos = 8'h00;
                  d.busy = 1'b1;
                  d.st = TCP_T_SEND;
               end
            end
         end
         TCP_T_SEND: begin
            d.byte_valid = 1'b1;
            d.byte_data = q.msg[q.pos];
            d.pos = q.pos + 8'h01;
            if (q.pos == q.lc - 8'h01) begin
               d.st = TCP_T_WAIT;
            end
         end
         TCP_T_WAIT: begin
            if (lnk.resp_valid) begin
               d.done = 1'b1;
               d.ok = lnk.resp_ok;
               d.busy = 1'b0;
               d.st = TCP_T_IDLE;
            end
         end
         default: begin
            d.st = TCP_T_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign lnk.session_new = q.session_new;
   assign lnk.cmd_valid = q.cmd_valid;
   assign lnk.cmd_lc = q.lc;
   assign lnk.byte_valid = q.byte_valid;
   assign lnk.byte_data = q.byte_data;
   assign busy = q.busy;
   assign done = q.done;
   assign ok = q.ok;
   assign refused = q.refused;
endmodule

// ===== tcp_link_sva.sv
`timescale 1ns/1ps
module tcp_link_sva (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic session_new,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_lc,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic cap_adv,
   input wire logic resp_valid,
   input wire logic resp_ok
);
   // Bytes still owed to the open command
   logic [7:0] rem_q;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) rem_q <= 8'h00;
      else if (cmd_valid) rem_q <= cmd_lc;
      else if (byte_valid && rem_q != 8'h00) rem_q <= rem_q - 8'h01;
   end
   // ==========================================
   // Command framing
   sequence s_cont;
      byte_valid && byte_data == 8'ha9 ##1 byte_valid && byte_data == $past(cmd_lc, 2) - 8'h02;
   endsequence
   sequence s_pwr;
      byte_valid && byte_data == 8'h80 ##1 byte_valid && byte_data == 8'h03;
   endsequence
   AST_NO_CMD_UNADV: assert property (cmd_valid |-> cap_adv) else $error("command without advert");
   AST_CONT_HDR: assert property (cmd_valid |=> s_cont) else $error("bad container header");
   AST_PWR_FIRST: assert property (cmd_valid |=> ##2 s_pwr) else $error("power object missing");
   AST_LC_MIN: assert property (cmd_valid |-> cmd_lc >= 8'h07) else $error("Lc too short");
   AST_BYTES_BURST: assert property (cmd_valid |=> byte_valid [*7]) else $error("byte gap");
   AST_RESP_AT_END: assert property (byte_valid && rem_q == 8'h01 |=> resp_valid) else $error("late resp");
   AST_RESP_PULSE: assert property (resp_valid |=> !resp_valid) else $error("resp too long");
   AST_RESP_GOOD: assert property (resp_valid |-> resp_ok) else $error("valid command refused");
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clock, arst_n, session_start, start, ext_en, clf_en, emb_en, busy, done, ok, refused;
   logic [7:0] volt_class, max_current, clk_freq, clf_byte, emb_len;
   logic [63:0] emb_data;
   logic [3:0] emb_rd_addr;
   logic [7:0] c_rd, c_elen, c_volt, c_cur, c_freq, d_cur, d_freq;
   logic [4:0] c_max_ch;
   logic c_eseen, c_pwr, c_cur_ok, c_freq_ok, c_ext, c_clf, d_ext, d_clf;
   int fail_count, check_count, cycles;
   tcp_link_if lnk ();
   tcp_link_if lnk2 ();
   tcp_term tcp_term_inst (.clock(clock), .arst_n(arst_n), .lnk(lnk), .session_start(session_start),
      .start(start), .volt_class(volt_class), .max_current(max_current), .clk_freq(clk_freq),
      .ext_en(ext_en), .clf_en(clf_en), .clf_byte(clf_byte), .emb_en(emb_en), .emb_len(emb_len),
      .emb_data(emb_data), .busy(busy), .done(done), .ok(ok), .refused(refused));
   tcp_card tcp_card_inst (.clock(clock), .arst_n(arst_n), .lnk(lnk), .emb_rd_addr(emb_rd_addr),
      .emb_rd_data(c_rd), .emb_len(c_elen), .embedded_provisioned_card(c_eseen), .pwr_seen(c_pwr),
      .volt_class(c_volt), .max_current(c_cur), .current_ok(c_cur_ok), .clk_freq(c_freq),
      .freq_ok(c_freq_ok), .ext_channels(c_ext), .max_channel(c_max_ch), .contactless_frontend_link(c_clf));
   // Second card faces the bench, which sends what a real terminal never would
   tcp_card tcp_card_inst_b (.clock(clock), .arst_n(arst_n), .lnk(lnk2), .emb_rd_addr(4'h0),
      .emb_rd_data(), .emb_len(), .embedded_provisioned_card(), .pwr_seen(), .volt_class(),
      .max_current(d_cur), .current_ok(), .clk_freq(d_freq), .freq_ok(), .ext_channels(d_ext),
      .max_channel(), .contactless_frontend_link(d_clf));
   tcp_link_sva tcp_link_sva_inst (.clock(clock), .arst_n(arst_n), .session_new(lnk.session_new),
      .cmd_valid(lnk.cmd_valid), .cmd_lc(lnk.cmd_lc), .byte_valid(lnk.byte_valid),
      .byte_data(lnk.byte_data), .cap_adv(lnk.cap_adv), .resp_valid(lnk.resp_valid), .resp_ok(lnk.resp_ok));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // ==========================================
   // Shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic run_cmd;
      int n;
      n = 0;
      @(posedge clock) start <= 1'b1;
      @(posedge clock) start <= 1'b0;
      @(negedge clock);
      chk(busy, 8'h01, "busy after start");
      do @(negedge clock); while (done !== 1'b1 && ++n < 60);
      if (done !== 1'b1) begin
         fail_count++;
         $display("[FAIL] %0t no done", $time);
      end
      chk(ok, 8'h01, "command status");
      chk(busy, 8'h00, "busy falls with done");
   endtask
   task automatic sess;
      @(posedge clock) session_start <= 1'b1;
      @(posedge clock) session_start <= 1'b0;
      repeat (3) @(negedge clock);
   endtask
   task automatic raw(input logic [7:0] b[$]);
      int n;
      n = 0;
      @(posedge clock) lnk2.cmd_valid <= 1'b1;
      lnk2.cmd_lc <= 8'(b.size());
      foreach (b[i]) begin
         @(posedge clock) lnk2.cmd_valid <= 1'b0;
         lnk2.byte_valid <= 1'b1;
         lnk2.byte_data <= b[i];
      end
      @(posedge clock) lnk2.byte_valid <= 1'b0;
      lnk2.byte_data <= ~lnk2.byte_data;
      do @(negedge clock); while (lnk2.resp_valid !== 1'b1 && ++n < 8);
      if (n == 8) begin
         fail_count++;
         $display("[FAIL] %0t no response", $time);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic test_defaults;
      sess;
      chk(c_freq, 8'hff, "freq default");
      chk(8'(c_max_ch), 8'h03, "channel limit");
      chk(c_pwr, 8'h00, "power flag");
      $display("test_defaults end");
   endtask
   task automatic test_power;
      logic [7:0] tc[4] = '{8'h0a, 8'h3c, 8'h09, 8'h3d};
      logic [7:0] tf[4] = '{8'h0a, 8'hfe, 8'h09, 8'hff};
      logic [7:0] ok_c[4] = '{8'h01, 8'h01, 8'h00, 8'h00};
      for (int i = 0; i < 4; i++) begin
         @(posedge clock) max_current <= tc[i];
         clk_freq <= tf[i];
         run_cmd;
         chk(c_cur, tc[i], "current");
         chk(c_cur_ok, ok_c[i], "current range");
         chk(c_freq, tf[i], "freq");
         chk(c_freq_ok, ok_c[i], "freq range");
         chk(c_volt, 8'h91, "voltage class");
         chk(c_pwr, 8'h01, "power seen");
      end
      $display("test_power end");
   endtask
   task automatic test_objects;
      @(posedge clock) ext_en <= 1'b1;
      clf_en <= 1'b1;
      clf_byte <= 8'hfe;
      emb_en <= 1'b1;
      emb_len <= 8'h03;
      emb_data <= 64'h0000_0000_00c3_b2a1;
      run_cmd;
      chk(c_ext, 8'h01, "extended flag");
      chk(8'(c_max_ch), 8'h13, "extended limit");
      chk(c_clf, 8'h00, "front-end clear");
      chk(c_elen, 8'h03, "embedded length");
      chk(c_eseen, 8'h01, "embedded seen");
      for (int i = 0; i < 3; i++) begin
         @(posedge clock) emb_rd_addr <= 4'(i);
         @(posedge clock);
         @(negedge clock);
         chk(c_rd, emb_data[8*i+:8], "embedded byte");
      end
      @(posedge clock) clf_byte <= 8'h01;
      run_cmd;
      chk(c_clf, 8'h01, "front-end set");
      $display("test_objects end");
   endtask
   task automatic test_session;
      sess;
      chk(c_ext, 8'h00, "extended cleared");
      chk(8'(c_max_ch), 8'h03, "limit restored");
      chk({c_clf, c_eseen}, 8'h00, "flags cleared");
      chk(c_freq, 8'hff, "freq cleared");
      $display("test_session end");
   endtask
   task automatic test_faults;
      @(posedge clock) lnk2.session_new <= 1'b1;
      @(posedge clock) lnk2.session_new <= 1'b0;
      raw('{8'ha9, 8'h11, 8'h80, 8'h03, 8'h11, 8'h20, 8'h64, 8'h81, 8'h02, 8'haa, 8'hbb,
            8'h82, 8'h03, 8'h01, 8'hff, 8'hff, 8'hc5, 8'h01, 8'h77});
      chk(lnk2.resp_ok, 8'h01, "odd objects accepted");
      chk(d_ext, 8'h01, "long extended object");
      chk(d_clf, 8'h01, "long interface object");
      chk(d_freq, 8'h64, "freq after skip");
      chk(d_cur, 8'h20, "current");
      raw('{8'hb9, 8'h02, 8'h81, 8'h00});
      chk(lnk2.resp_ok, 8'h00, "wrong container tag");
      raw('{8'ha9, 8'h03, 8'h80, 8'h03, 8'h11});
      chk(lnk2.resp_ok, 8'h00, "object overrun");
      $display("test_faults end");
   endtask
   // Mid-run reset; a start on the first edge after release meets no advert yet
   task automatic test_refuse;
      @(posedge clock) arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      start <= 1'b1;
      @(posedge clock) start <= 1'b0;
      @(negedge clock);
      chk(refused, 8'h01, "refused before advert");
      chk(busy, 8'h00, "idle after refusal");
      chk(lnk.cap_adv, 8'h01, "advert after reset");
      @(negedge clock);
      chk(refused, 8'h00, "refusal pulse");
      chk(lnk.cmd_valid, 8'h00, "nothing sent");
      sess;
      chk(c_freq, 8'hff, "freq after reset");
      $display("test_refuse end");
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         $display("[FAIL] %0t timeout", $time);
         final_report;
      end
   end
   initial begin
      arst_n = 1'b0;
      {session_start, start, ext_en, clf_en, emb_en} = 5'h00;
      volt_class = 8'h91;
      max_current = 8'h1e;
      clk_freq = 8'hff;
      clf_byte = 8'h00;
      emb_len = 8'h00;
      emb_data = 64'h0;
      emb_rd_addr = 4'h0;
      {lnk2.session_new, lnk2.cmd_valid, lnk2.byte_valid} = 3'h0;
      lnk2.cmd_lc = 8'h00;
      lnk2.byte_data = 8'h00;
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      test_defaults;
      test_power;
      test_objects;
      test_session;
      test_faults;
      test_refuse;
      final_report;
   end
endmodule
